// file: wdt_pkg.sv
package wdt_pkg;

  // counter geometry
  localparam int PRE_W = 12;
  localparam int WD_W  = 6;
  localparam int CNT_W = PRE_W + WD_W;
  // prescaler stages cleared by a service write (stages 12..5)
  localparam int SVC_LO = 4;

  // timeouts in internal oscillator cycles
  localparam logic [17:0] LONG_LIMIT  = 18'h3FFF0;
  localparam logic [17:0] SHORT_LIMIT = 18'h01FF0;
  localparam int          PULSE_TICKS = 32;
  localparam int          POR_TICKS   = 4096;

  // register indices; byte address is four times the index
  localparam int          ADDR_W      = 18;
  localparam logic [15:0] IDX_SERVICE = 16'hFFFF;
  localparam logic [15:0] IDX_OPTION  = 16'h0000;
  localparam logic [15:0] IDX_CAUSE   = 16'h0001;
  localparam logic [15:0] IDX_EVT     = 16'h0002;
  localparam logic [15:0] IDX_MASK    = 16'h0003;
  localparam logic [15:0] IDX_STATUS  = 16'h0004;

  // field positions
  localparam int OPT_DISABLE  = 0;
  localparam int OPT_RATE     = 1;
  localparam int CAUSE_WD     = 0;
  localparam int EVT_TIMEOUT  = 0;
  localparam int EVT_SERVICE  = 1;
  localparam int EVT_W        = 2;

  // reset values
  localparam logic [7:0]       OPT_RST   = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST   = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RST  = 2'h0;

  typedef struct packed {
    logic [5:0] spare;
    logic       rate_select;
    logic       disable_bit;
  } wdt_opt_t;

  typedef enum logic [0:0] {
    WDT_IDLE  = 1'b0,
    WDT_PULSE = 1'b1
  } wdt_state_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

endpackage : wdt_pkg

// file: wdt_sync.sv
module wdt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // two stages, the first read only by the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : wdt_sync

// file: wdt_top.sv
// What this block does
// - 6-bit watchdog counter runs on the carry of a 12-bit prescaler
// - unserviced, counter expires after 2^18-2^4 or 2^13-2^4 oscillator cycles
// - any write to service location clears watchdog and prescaler stages 12..5
// - reading the service location returns the reset vector low byte
// - expiry holds reset pin low 32 cycles and sets the cause bit
// - prescaler cleared once 4096 oscillator cycles after power-up
// - internal reset clears prescaler and watchdog counter
// - reset vector fetch clears the prescaler
// - disable bit set means the watchdog never resets
// - reset clears rate select, choosing the long period
// - watchdog never raises a processor interrupt, only reset
// - held off in monitor mode with high test voltage on either pin
// - time base is the slow internal oscillator clock
// - stop mode gates the time base and clears prescaler; wait keeps counting
// - during break, disabled when high test voltage is on reset pin
module wdt_top #(
  parameter logic [17:0] LONG_TICKS  = wdt_pkg::LONG_LIMIT,
  parameter logic [17:0] SHORT_TICKS = wdt_pkg::SHORT_LIMIT,
  parameter int          POR_COUNT   = wdt_pkg::POR_TICKS
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // oscillator and pins
  input  wire logic                      internal_osc_clock,
  input  wire logic                      hv_on_irq_pin,
  input  wire logic                      hv_on_reset_pin,
  input  wire logic                      rst_pin_i,
  output logic                           rst_pin_o,
  output logic                           rst_pin_oe,
  // system side
  input  wire logic [7:0]                reset_vector_lo,
  input  wire logic                      vector_fetch,
  input  wire logic                      internal_reset,
  input  wire logic                      monitor_mode,
  input  wire logic                      break_active,
  input  wire logic                      stop_mode,
  input  wire logic                      wait_mode,
  output logic                           wd_reset,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and time base

  logic [3:0] pins_s;
  logic       internal_osc_clock_prev_q;
  wdt_sync #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       ({rst_pin_i, hv_on_reset_pin, hv_on_irq_pin, internal_osc_clock}),
    .q       (pins_s)
  );

  wire internal_osc_clock_s   = pins_s[0];
  wire hv_irq_s = pins_s[1];
  wire hv_rst_s = pins_s[2];
  wire pin_s    = pins_s[3];

  // oscillator edge; slow clock sampled, so it must stay well below clk_sys/4
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) internal_osc_clock_prev_q <= 1'b0;
    else         internal_osc_clock_prev_q <= internal_osc_clock_s;
  end
  wire tick     = internal_osc_clock_s & ~internal_osc_clock_prev_q;
  // wait mode changes nothing here: counting carries on
  wire run_tick = tick & ~stop_mode;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [31:0]  prdata_q;
  logic         pready_q, pslverr_q;
  wdt_pkg::wdt_opt_t opt_q;
  logic [7:0]   cause_q;
  logic [wdt_pkg::EVT_W-1:0] evt_q, mask_q;
  logic [wdt_pkg::PRE_W-1:0] pre_q, pre_d;
  logic [wdt_pkg::WD_W-1:0]  wd_q, wd_d;
  wdt_pkg::wdt_state_t state_q;

  wire setup  = psel & ~penable;
  wire wr_en  = psel & penable & pwrite & pready_q;
  wire hit_svc = paddr == wdt_pkg::byte_addr(wdt_pkg::IDX_SERVICE);
  wire hit_opt = paddr == wdt_pkg::byte_addr(wdt_pkg::IDX_OPTION);
  wire hit_cau = paddr == wdt_pkg::byte_addr(wdt_pkg::IDX_CAUSE);
  wire hit_evt = paddr == wdt_pkg::byte_addr(wdt_pkg::IDX_EVT);
  wire hit_msk = paddr == wdt_pkg::byte_addr(wdt_pkg::IDX_MASK);
  wire hit_sta = paddr == wdt_pkg::byte_addr(wdt_pkg::IDX_STATUS);
  wire mapped  = hit_svc | hit_opt | hit_cau | hit_evt | hit_msk | hit_sta;
  // any data value counts
  wire svc_wr  = wr_en & hit_svc;

  // read mux; service location answers with vector byte, never counter state
  wire [31:0] rd_mux =
      hit_svc ? {24'h000000, reset_vector_lo} :
      hit_opt ? {24'h000000, opt_q} :
      hit_cau ? {24'h000000, cause_q} :
      hit_evt ? {30'h00000000, evt_q} :
      hit_msk ? {30'h00000000, mask_q} :
      hit_sta ? {11'h000, pin_s, state_q, wd_q, pre_q, 1'b0} : 32'h00000000;

  // zero-wait answer: pready high in the first access cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable, expiry and counters

  logic [4:0] pulse_cnt_q;
  logic [12:0] por_cnt_q;
  logic        por_done_q;

  wire mon_hold = monitor_mode & (hv_irq_s | hv_rst_s);
  wire brk_hold = break_active & hv_rst_s;
  wire wd_on    = ~opt_q.disable_bit & ~mon_hold & ~brk_hold;
  wire [17:0] limit = opt_q.rate_select ? SHORT_TICKS : LONG_TICKS;
  // the watchdog counter takes the prescaler carry
  wire [17:0] cnt_inc = {wd_q, pre_q} + 18'h00001;
  wire in_pulse = state_q == wdt_pkg::WDT_PULSE;
  wire expire   = wd_on & run_tick & ~in_pulse & (cnt_inc == limit);
  wire por_hit  = tick & ~por_done_q & (por_cnt_q == 13'(POR_COUNT - 1));
  // a watchdog reset acts as an internal reset on the counters
  wire clr_all  = internal_reset | expire | in_pulse;
  wire pre_clr  = vector_fetch | stop_mode | por_hit;

  // counter next state; clears ordered weakest to strongest
  always_comb begin
    {wd_d, pre_d} = {wd_q, pre_q};
    if (run_tick) {wd_d, pre_d} = cnt_inc;
    if (svc_wr) begin
      pre_d[wdt_pkg::PRE_W-1:wdt_pkg::SVC_LO] = '0;
      wd_d = '0;
    end
    if (pre_clr) pre_d = '0;
    if (clr_all) begin
      pre_d = '0;
      wd_d  = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
      wd_q  <= '0;
    end else begin
      pre_q <= pre_d;
      wd_q  <= wd_d;
    end
  end

  // power-up prescaler clear, once
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      por_cnt_q  <= 13'h0000;
      por_done_q <= 1'b0;
    end else if (tick & ~por_done_q) begin
      por_cnt_q  <= por_cnt_q + 13'h0001;
      por_done_q <= por_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse on the pin

  wire pulse_end = in_pulse & tick & (pulse_cnt_q == 5'(wdt_pkg::PULSE_TICKS - 1));

  // counts oscillator edges, even in stop, so the pin is always released
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q     <= wdt_pkg::WDT_IDLE;
      pulse_cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        wdt_pkg::WDT_IDLE: begin
          pulse_cnt_q <= 5'h00;
          if (expire) state_q <= wdt_pkg::WDT_PULSE;
        end
        wdt_pkg::WDT_PULSE: begin
          if (tick) pulse_cnt_q <= pulse_cnt_q + 5'h01;
          if (pulse_end) state_q <= wdt_pkg::WDT_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_pin_o  <= 1'b0;
      rst_pin_oe <= 1'b0;
      wd_reset   <= 1'b0;
    end else begin
      rst_pin_o  <= 1'b0;
      rst_pin_oe <= (expire | in_pulse) & ~pulse_end;
      wd_reset   <= (expire | in_pulse) & ~pulse_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  wire [wdt_pkg::EVT_W-1:0] evt_set = {svc_wr, expire};
  wire [wdt_pkg::EVT_W-1:0] evt_w1c = (wr_en & hit_evt) ? pwdata[wdt_pkg::EVT_W-1:0] : '0;
  wire cause_w1c = wr_en & hit_cau & pwdata[wdt_pkg::CAUSE_WD];

  // options; any reset restores the long period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) opt_q <= wdt_pkg::OPT_RST;
    else if (internal_reset | expire) opt_q <= wdt_pkg::OPT_RST;
    else if (wr_en & hit_opt) opt_q <= {6'h00, pwdata[wdt_pkg::OPT_RATE],
                                        pwdata[wdt_pkg::OPT_DISABLE]};
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cause_q <= 8'h00;
      evt_q   <= wdt_pkg::EVT_RST;
      mask_q  <= wdt_pkg::MASK_RST;
    end else begin
      cause_q[wdt_pkg::CAUSE_WD] <= expire | (cause_q[wdt_pkg::CAUSE_WD] & ~cause_w1c);
      evt_q <= evt_set | (evt_q & ~evt_w1c);
      if (wr_en & hit_msk) mask_q <= pwdata[wdt_pkg::EVT_W-1:0];
    end
  end

  // system event line, separate from any processor interrupt path
  // the mask covers the set path too, so a masked event never pulses the line
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) irq <= 1'b0;
    else         irq <= |((evt_set | (evt_q & ~evt_w1c)) & mask_q);
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_service_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    svc_wr |=> wd_q == '0) else $error("service write left watchdog counter set");
  a_expire_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire |=> in_pulse && rst_pin_oe) else $error("expiry did not drive reset pin");
  a_cause_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire |=> cause_q[0]) else $error("cause bit not set on expiry");
  a_disable_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    opt_q.disable_bit && !in_pulse |=> !rst_pin_oe) else $error("disabled watchdog drove pin");
  a_vector_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    vector_fetch |=> pre_q == '0) else $error("vector fetch left prescaler");
  a_int_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    internal_reset |=> pre_q == '0 && wd_q == '0) else $error("internal reset left counters");
  a_stop_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    stop_mode |=> pre_q == '0) else $error("stop mode left prescaler");
  a_read_vector: assert property (@(posedge clk_sys) disable iff (!resetn)
    setup && !pwrite && hit_svc |=> prdata == {24'h000000, $past(reset_vector_lo)})
    else $error("service read did not return vector byte");
  a_monitor_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    mon_hold && !in_pulse |=> !wd_reset) else $error("watchdog reset in monitor mode");

  // break hold, pin pulse, counter stepping and clears, the default options and the event mask
  a_break_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    brk_hold && !in_pulse |=> !rst_pin_oe) else $error("watchdog reset during break");
  a_pin_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
    rst_pin_oe == wd_reset && !rst_pin_o) else $error("reset pin and reset out disagree");
  a_pulse_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    pulse_end |=> !rst_pin_oe && !in_pulse) else $error("reset pin held past pulse end");
  a_pulse_counters: assert property (@(posedge clk_sys) disable iff (!resetn)
    in_pulse |=> wd_q == '0 && pre_q == '0) else $error("counters ran during reset pulse");
  a_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    run_tick && !svc_wr && !pre_clr && !clr_all |=>
      {wd_q, pre_q} == 18'($past({wd_q, pre_q}) + 18'h00001))
    else $error("watchdog count did not step on tick");
  a_wait_counts: assert property (@(posedge clk_sys) disable iff (!resetn)
    wait_mode && run_tick && !svc_wr && !pre_clr && !clr_all |=> pre_q != $past(pre_q))
    else $error("prescaler stalled in wait mode");
  a_service_stages: assert property (@(posedge clk_sys) disable iff (!resetn)
    svc_wr |=> pre_q[wdt_pkg::PRE_W-1:wdt_pkg::SVC_LO] == '0)
    else $error("service write left upper prescaler stages");
  a_por_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    por_hit |=> pre_q == '0) else $error("power-up clear missed prescaler");
  a_rate_default: assert property (@(posedge clk_sys) disable iff (!resetn)
    internal_reset |=> !opt_q.rate_select) else $error("internal reset kept short period");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!resetn)
    mask_q == '0 |=> !irq) else $error("event line raised with all events masked");

endmodule : wdt_top

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        rd;
    logic [31:0] d;
    logic        e;
  } wdt_note_t;

  localparam logic [17:0] LT = 18'h00100;
  localparam logic [17:0] ST = 18'h00030;

  logic        clk_sys, resetn, psel, penable, pwrite, osc, hv_irq, hv_rst;
  logic        vf, irst, mon, brk, stp, wt, pready, pslverr, wd_reset, irq;
  logic        rst_pin_o, rst_pin_oe, wd_q;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  vec_lo;
  logic [2:0]  div_q;
  wire         rst_level;
  int          fail_count, checks, ticks, rises, seed, n, r0, t_rel;
  wdt_note_t   notes[$];
  wdt_note_t   nt;

  // open-drain reset pin with pull-up: a released pin reads high
  assign rst_level = rst_pin_oe ? rst_pin_o : 1'b1;

  wdt_top #(.LONG_TICKS(LT), .SHORT_TICKS(ST), .POR_COUNT(16)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_osc_clock(osc),
    .hv_on_irq_pin(hv_irq), .hv_on_reset_pin(hv_rst), .rst_pin_i(rst_level),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .reset_vector_lo(vec_lo),
    .vector_fetch(vf), .internal_reset(irst), .monitor_mode(mon),
    .break_active(brk), .stop_mode(stp), .wait_mode(wt), .wd_reset(wd_reset),
    .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // slow oscillator, one tick per 8 clocks; our own tick count times the pulses
  always @(posedge clk_sys) begin
    div_q <= div_q + 3'h1;
    osc   <= div_q[2];
    if (div_q == 3'h3) ticks <= ticks + 1;
    wd_q  <= wd_reset;
    if (wd_reset === 1'b1 && wd_q !== 1'b1) rises <= rises + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // answer watcher: each completed transfer retires the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0, "stray answer");
      else begin
        nt = notes.pop_front();
        if (nt.rd) check(prdata, nt.d, "read data");
        check(32'(pslverr), 32'(nt.e), "error flag");
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request held until pready is sampled high, released only after that edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    notes.push_back('{rd: !wr, d: exp, e: err});
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ticks(input int k);
    int t0;
    t0 = ticks;
    while (ticks - t0 < k) @(posedge clk_sys);
  endtask : wait_ticks

  // fresh period: service clears the counter, a fetch the whole prescaler
  task automatic restart();
    apb(1'b1, wdt_pkg::IDX_SERVICE, $random(seed), 32'h0, 1'b0);
    @(posedge clk_sys) vf <= 1'b1;
    @(posedge clk_sys) vf <= 1'b0;
  endtask : restart

  task automatic until_rst(input int t0, input int lim, input string what);
    while (wd_reset !== 1'b1 && ticks - t0 < 2000) @(posedge clk_sys);
    check(32'(ticks - t0 >= lim - 1 && ticks - t0 <= lim + 1), 32'h1, what);
  endtask : until_rst

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    $display("[ERR] %0t run too long", $time);
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hf6a3;
    {resetn, psel, penable, pwrite, osc, hv_irq, hv_rst, vf, irst} = '0;
    {mon, brk, stp, wt, wd_q, div_q, paddr, pwdata} = '0;
    vec_lo = 8'($random(seed));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_rel = ticks;
    apb(1'b0, wdt_pkg::IDX_OPTION, 32'h0, 32'h0, 1'b0);
    apb(1'b0, wdt_pkg::IDX_CAUSE, 32'h0, 32'h0, 1'b0);
    apb(1'b0, wdt_pkg::IDX_SERVICE, 32'h0, {24'h0, vec_lo}, 1'b0);
    apb(1'b0, 16'h0040, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 16'h0040, $random(seed), 32'h0, 1'b1);
    $display("test reset values done");
    // unserviced from reset: power-up clear at tick 16, then the long period
    until_rst(t_rel, 16 + LT, "first expiry");
    check(32'(rst_level), 32'h0, "pin low");
    check(32'(irq), 32'h0, "masked event");
    // mid-pulse status: pulse state set, counters held, pin seen low
    apb(1'b0, wdt_pkg::IDX_STATUS, 32'h0, 32'h00080000, 1'b0);
    r0 = ticks;
    while (wd_reset === 1'b1) @(posedge clk_sys);
    check(32'(ticks - r0 >= 31 && ticks - r0 <= 33), 32'h1, "pulse length");
    apb(1'b0, wdt_pkg::IDX_CAUSE, 32'h0, 32'h1, 1'b0);
    apb(1'b0, wdt_pkg::IDX_EVT, 32'h0, 32'h1, 1'b0);
    apb(1'b1, wdt_pkg::IDX_MASK, 32'h1, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h1, "event unmasked");
    apb(1'b1, wdt_pkg::IDX_EVT, 32'h1, 32'h0, 1'b0);
    apb(1'b1, wdt_pkg::IDX_CAUSE, 32'h1, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h0, "event cleared");
    apb(1'b0, wdt_pkg::IDX_CAUSE, 32'h0, 32'h0, 1'b0);
    $display("test long expiry done");
    apb(1'b1, wdt_pkg::IDX_OPTION, 32'h2, 32'h0, 1'b0);
    apb(1'b0, wdt_pkg::IDX_OPTION, 32'h0, 32'h2, 1'b0);
    restart();
    until_rst(ticks, ST, "short expiry");
    while (wd_reset === 1'b1) @(posedge clk_sys);
    $display("test short expiry done");
    // services with random data keep a short period alive
    apb(1'b1, wdt_pkg::IDX_OPTION, 32'h2, 32'h0, 1'b0);
    restart();
    r0 = rises;
    repeat (6) begin
      wait_ticks(24);
      apb(1'b1, wdt_pkg::IDX_SERVICE, $random(seed), 32'h0, 1'b0);
    end
    check(32'(rises - r0), 32'h0, "serviced expiry");
    // a masked service event must not reach the event line, not even for a cycle
    apb(1'b1, wdt_pkg::IDX_EVT, 32'h3, 32'h0, 1'b0);
    apb(1'b1, wdt_pkg::IDX_SERVICE, $random(seed), 32'h0, 1'b0);
    @(posedge clk_sys);
    check(32'(irq), 32'h0, "masked service event");
    apb(1'b0, wdt_pkg::IDX_EVT, 32'h0, 32'h2, 1'b0);
    $display("test service done");
    // inhibit table: disable, monitor with either pin, break, stop; wait counts
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, wdt_pkg::IDX_OPTION, (m == 0) ? 32'h3 : 32'h2, 32'h0, 1'b0);
      restart();
      r0 = rises;
      mon    <= (m == 1 || m == 2);
      hv_irq <= (m == 1);
      hv_rst <= (m == 2 || m == 3);
      brk    <= (m == 3);
      stp    <= (m == 4);
      wt     <= (m == 5);
      wait_ticks(2 * ST);
      check(32'(rises - r0), (m == 5) ? 32'h1 : 32'h0, "inhibit");
      while (wd_reset === 1'b1) @(posedge clk_sys);
      restart();
      {mon, hv_irq, hv_rst, brk, stp, wt} <= '0;
    end
    $display("test inhibit done");
    // internal reset clears counters and rate select: a full long period follows
    apb(1'b1, wdt_pkg::IDX_OPTION, 32'h2, 32'h0, 1'b0);
    wait_ticks(20);
    @(posedge clk_sys) irst <= 1'b1;
    @(posedge clk_sys) irst <= 1'b0;
    until_rst(ticks, LT, "after internal reset");
    $display("test internal reset done");
    give_verdict();
  end

endmodule : tb
